// ===== pmic_bank_regs.svh
// Register indices, field positions, reset values and timing counts of the regulator bank.
// Assumes AXI4-Lite byte addresses equal four times the register index.
`ifndef PMIC_BANK_REGS_SVH
`define PMIC_BANK_REGS_SVH

`define IDX_SWITCHER_MODE_UPPER 6'h1D
`define IDX_LINEAR_VOLTAGE 6'h1E
`define IDX_BOOST_CONTROL 6'h1F
`define IDX_LINEAR_ENABLE_MODE 6'h20
`define IDX_PIN0_CONTROL 6'h21
`define IDX_IRQ_STATUS 6'h22
`define IDX_IRQ_CLEAR 6'h23
`define IDX_IRQ_ENABLE 6'h24

`define SW_MODE_RESET 24'h28A28A
`define SW_MODE_FIELD_MASK 24'h3CF3CF
`define SW_OFF_RESET_MASK 24'hC30C30
`define SW_FIELD_STRIDE 6
`define SW_MODE_DEFAULT 4'hA
`define SW_MODE_APS 4'h8
`define SW_MODE_OFF 4'h0

`define LIN_VOLT_MASK 24'h001FF7
`define BOOST_MASK 24'h0000FF
`define BOOST_MAIN_MASK 24'h0000FC
`define BOOST_RESET 24'h000048
`define LIN_EN_MASK 24'h1FFC7F
`define LIN_EN_WR_MASK 24'h1DF47F
`define LIN_EN_MAIN_MASK 24'h19606A
`define LIN_EN_RESET 24'h000008
`define LIN_USB_ON_BIT 3
`define LIN_GEN2_PASS_BIT 11
`define LIN_USB2_PASS_BIT 17

`define PIN_MASK 24'h00FFFF
`define PIN_WR_MASK 24'h00FFFD
`define PIN_RESET 24'h003808
`define PIN_DIR_BIT 0
`define PIN_DIN_BIT 1
`define PIN_DOUT_BIT 2
`define PIN_HYS_BIT 3
`define PIN_DEBOUNCE_SELECT_LSB 4
`define PIN_INT_LSB 6
`define PIN_KEEP_BIT 8
`define PIN_OD_BIT 9
`define PIN_DRIVE_BIT 10
`define PIN_PULL_EN_BIT 11
`define PIN_PULL_SEL_LSB 12
`define PIN_SLEW_LSB 14

`define IRQ_PIN_BIT 0
`define IRQ_VBUS_BIT 1
`define STRAP_PASS_BIT 4

`define CLK_HZ 10000000
`define DEBOUNCE_STEP_MS 10
`define CYCLES_PER_MS (`CLK_HZ / 1000)

`endif

// ===== pmic_bank_pkg.sv
// Types shared by the regulator bank and its debounce filter.
// Assumes the constants header is included where numbers are needed.
`default_nettype none
package pmic_bank_pkg;

   typedef struct packed {
      logic hysteresis;
      logic keeper;
      logic strong_drive;
      logic pull_enable;
      logic [1:0] pull_select;
      logic [1:0] slew;
   } pad_cfg_t;

   typedef enum logic [1:0] {EDGE_NONE, EDGE_FALL, EDGE_RISE, EDGE_BOTH} edge_sel_t;

   typedef enum logic [1:0] {SEQ_WAIT, SEQ_LOAD, SEQ_RUN} seq_state_t;

endpackage : pmic_bank_pkg
`default_nettype wire

// ===== pin_debounce.sv
// Debounce filter for the low-voltage pin input.
// Assumes level_in is already synchronised and tick_ms pulses once per millisecond.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_bank_regs.svh"

module pin_debounce #(
   parameter int CNT_W = 6
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tick_ms,
   input wire logic level_in,
   input wire logic [1:0] debounce_select,
   output logic level_out
);
   import pmic_bank_pkg::*;

   logic [CNT_W-1:0] stable_ms_reg;
   logic [CNT_W-1:0] limit_ms;

   if (CNT_W < 5) begin : g_cnt_check
      $error("pin_debounce: CNT_W too small for 30 ms");
   end

   // Stable time needed is the code times ten milliseconds
   assign limit_ms = CNT_W'(debounce_select) * CNT_W'(`DEBOUNCE_STEP_MS);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stable_ms_reg <= '0;
      end else if (level_in == level_out) begin
         stable_ms_reg <= '0;
      end else if (tick_ms) begin
         stable_ms_reg <= stable_ms_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level_out <= 1'b0;
      end else if (debounce_select == 2'b00) begin
         level_out <= level_in;
      end else if (level_in != level_out && tick_ms && stable_ms_reg >= limit_ms) begin
         level_out <= level_in;
      end
   end

   AST_DB_BYPASS: assert property (@(posedge mclk) disable iff (!rst_n)
      debounce_select == 2'b00 |=> level_out == $past(level_in))
      else $error("bypassed filter did not follow input");

   AST_DB_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      (debounce_select != 2'b00 && !tick_ms) |=> $stable(level_out))
      else $error("filtered level changed without a millisecond tick");

endmodule : pin_debounce
`default_nettype wire

// ===== pmic_regulator_gpio_regs.sv
// Regulator and low-voltage pin control bank behind an AXI4-Lite slave.
// Assumes pins, straps and reset pins are asynchronous to mclk.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_bank_regs.svh"

module pmic_regulator_gpio_regs #(
   parameter int MS_CYCLES = `CYCLES_PER_MS,
   parameter int STRAP_W = 5
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic main_reset_n,
   input wire logic off_reset_n,
   input wire logic [STRAP_W-1:0] powerup_strap,
   input wire logic [3:0] switcher_startup_en,
   input wire logic vbus_invalid,
   input wire logic standby,
   input wire logic low_voltage_pin0_in,
   output logic low_voltage_pin0_out,
   output logic low_voltage_pin0_oe_n,
   output pmic_bank_pkg::pad_cfg_t pin0_pad_cfg,
   output logic [23:0] switcher_mode_word,
   output logic [23:0] linear_voltage_word,
   output logic [23:0] boost_control_word,
   output logic [4:0] linear_reg_on,
   output logic usb_regulator_on,
   output logic irq
);
   import pmic_bank_pkg::*;

   localparam int SYNC_W = STRAP_W + 9;

   if (STRAP_W <= `STRAP_PASS_BIT) begin : g_strap_check
      $error("strap input too narrow");
   end
   if (MS_CYCLES < 2) begin : g_ms_check
      $error("MS_CYCLES must be at least 2");
   end

   // Two-flop synchronisers for every asynchronous input
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {powerup_strap, switcher_startup_en, vbus_invalid, standby,
                       low_voltage_pin0_in, main_reset_n, off_reset_n};
         sync2_reg <= sync1_reg;
      end
   end

   logic off_s, main_s, pin_s, stby_s, vbus_s;
   logic [3:0] sw_en_s;
   logic [STRAP_W-1:0] strap_s;
   assign off_s = sync2_reg[0];
   assign main_s = sync2_reg[1];
   assign pin_s = sync2_reg[2];
   assign stby_s = sync2_reg[3];
   assign vbus_s = sync2_reg[4];
   assign sw_en_s = sync2_reg[8:5];
   assign strap_s = sync2_reg[SYNC_W-1:9];

   // AXI4-Lite write side: address and data taken in either order
   logic aw_full_reg, w_full_reg;
   logic [5:0] aw_idx_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go;
   logic wr_hit;
   logic [23:0] wr_mask;

   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_mask = {{8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_idx_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[7:2];
         end else if (wr_go) begin
            aw_full_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (aw_idx_reg)
         `IDX_SWITCHER_MODE_UPPER, `IDX_LINEAR_VOLTAGE, `IDX_BOOST_CONTROL,
         `IDX_LINEAR_ENABLE_MODE, `IDX_PIN0_CONTROL, `IDX_IRQ_STATUS,
         `IDX_IRQ_CLEAR, `IDX_IRQ_ENABLE: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? 2'b00 : 2'b11;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] wmask);
      merge = (old & ~wmask) | (w_data_reg[23:0] & wmask);
   endfunction : merge

   logic wr_sw, wr_volt, wr_boost, wr_lin, wr_pin, wr_clr, wr_en;
   assign wr_sw = wr_go && aw_idx_reg == `IDX_SWITCHER_MODE_UPPER;
   assign wr_volt = wr_go && aw_idx_reg == `IDX_LINEAR_VOLTAGE;
   assign wr_boost = wr_go && aw_idx_reg == `IDX_BOOST_CONTROL;
   assign wr_lin = wr_go && aw_idx_reg == `IDX_LINEAR_ENABLE_MODE;
   assign wr_pin = wr_go && aw_idx_reg == `IDX_PIN0_CONTROL;
   assign wr_clr = wr_go && aw_idx_reg == `IDX_IRQ_CLEAR;
   assign wr_en = wr_go && aw_idx_reg == `IDX_IRQ_ENABLE;

   // Startup sequencer: one load after power-up and after each main reset
   seq_state_t seq_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg <= SEQ_WAIT;
      end else if (!main_s) begin
         seq_reg <= SEQ_WAIT;
      end else begin
         unique case (seq_reg)
            SEQ_WAIT: seq_reg <= SEQ_LOAD;
            SEQ_LOAD: seq_reg <= SEQ_RUN;
            SEQ_RUN: seq_reg <= SEQ_RUN;
         endcase
      end
   end

   // Switcher operating modes
   logic [23:0] sw_mode_reg, sw_mode_next;
   always_comb begin
      sw_mode_next = sw_mode_reg;
      if (wr_sw) begin
         sw_mode_next = merge(sw_mode_reg, wr_mask);
      end
      if (seq_reg == SEQ_LOAD) begin
         for (int i = 0; i < 4; i++) begin
            sw_mode_next[i*`SW_FIELD_STRIDE +: 4] = sw_en_s[i] ? `SW_MODE_APS
                                                               : `SW_MODE_OFF;
         end
      end
      if (!main_s) begin
         sw_mode_next = (sw_mode_next & ~`SW_MODE_FIELD_MASK) | `SW_MODE_RESET;
      end
      if (!off_s) begin
         sw_mode_next = sw_mode_next & ~`SW_OFF_RESET_MASK;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sw_mode_reg <= `SW_MODE_RESET;
      end else begin
         sw_mode_reg <= sw_mode_next;
      end
   end

   // Linear regulator voltages and boost control
   logic [23:0] volt_reg, boost_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         volt_reg <= '0;
         boost_reg <= `BOOST_RESET;
      end else begin
         if (!main_s) begin
            volt_reg <= '0;
         end else if (wr_volt) begin
            volt_reg <= merge(volt_reg, wr_mask & `LIN_VOLT_MASK);
         end
         if (!main_s) begin
            boost_reg <= (boost_reg & ~`BOOST_MAIN_MASK) | `BOOST_RESET;
         end else if (wr_boost) begin
            boost_reg <= merge(boost_reg, wr_mask & `BOOST_MASK);
         end
      end
   end

   // Linear regulator enables, standby control and pass-device straps
   logic [23:0] lin_reg, lin_next;
   always_comb begin
      lin_next = lin_reg;
      if (wr_lin) begin
         lin_next = merge(lin_reg, wr_mask & `LIN_EN_WR_MASK);
      end
      if (!main_s) begin
         lin_next = (lin_next & ~`LIN_EN_MAIN_MASK) | `LIN_EN_RESET;
      end
      if (seq_reg == SEQ_LOAD) begin
         lin_next[`LIN_GEN2_PASS_BIT] = strap_s[`STRAP_PASS_BIT];
         lin_next[`LIN_USB2_PASS_BIT] = strap_s[`STRAP_PASS_BIT];
      end
      if (!main_s || vbus_s) begin
         lin_next[`LIN_USB_ON_BIT] = 1'b1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lin_reg <= `LIN_EN_RESET;
      end else begin
         lin_reg <= lin_next;
      end
   end

   // Order: general 1, dac, general 2, pll, usb 2; each is enable and standby control
   logic [4:0] lin_en, lin_stby;
   assign lin_en = {lin_reg[18], lin_reg[15], lin_reg[12], lin_reg[4], lin_reg[0]};
   assign lin_stby = {lin_reg[19], lin_reg[16], lin_reg[13], lin_reg[5], lin_reg[1]};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         linear_reg_on <= '0;
      end else begin
         linear_reg_on <= lin_en & ~(lin_stby & {5{stby_s}});
      end
   end

   // Low-voltage pin control
   logic [23:0] pin_reg;
   logic pin_filt, pin_filt_d, tick_ms;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_reg <= `PIN_RESET;
      end else if (!main_s) begin
         pin_reg <= `PIN_RESET;
      end else if (wr_pin) begin
         pin_reg <= merge(pin_reg, wr_mask & `PIN_WR_MASK);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_voltage_pin0_out <= 1'b0;
         low_voltage_pin0_oe_n <= 1'b1;
         pin0_pad_cfg <= '0;
      end else begin
         low_voltage_pin0_out <= pin_reg[`PIN_DOUT_BIT] && !pin_reg[`PIN_OD_BIT];
         low_voltage_pin0_oe_n <= !(pin_reg[`PIN_DIR_BIT] &&
            !(pin_reg[`PIN_OD_BIT] && pin_reg[`PIN_DOUT_BIT]));
         pin0_pad_cfg <= '{hysteresis: pin_reg[`PIN_HYS_BIT], keeper: pin_reg[`PIN_KEEP_BIT],
            strong_drive: pin_reg[`PIN_DRIVE_BIT], pull_enable: pin_reg[`PIN_PULL_EN_BIT],
            pull_select: pin_reg[`PIN_PULL_SEL_LSB +: 2], slew: pin_reg[`PIN_SLEW_LSB +: 2]};
      end
   end

   // Millisecond enable for the debounce filter
   logic [$clog2(MS_CYCLES)-1:0] ms_cnt_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ms_cnt_reg <= '0;
      end else if (tick_ms) begin
         ms_cnt_reg <= '0;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 1'b1;
      end
   end
   assign tick_ms = ms_cnt_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);

   pin_debounce #(
      .CNT_W(6)
   ) u_debounce (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick_ms(tick_ms),
      .level_in(pin_s),
      .debounce_select(pin_reg[`PIN_DEBOUNCE_SELECT_LSB +: 2]),
      .level_out(pin_filt)
   );

   // Edge detection on the filtered pin level and on the unfiltered vbus flag
   edge_sel_t edge_sel;
   logic pin_event, vbus_d, vbus_event;
   assign edge_sel = edge_sel_t'(pin_reg[`PIN_INT_LSB +: 2]);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_filt_d <= 1'b0;
         vbus_d <= 1'b0;
      end else begin
         pin_filt_d <= pin_filt;
         vbus_d <= vbus_s;
      end
   end
   always_comb begin
      unique case (edge_sel)
         EDGE_NONE: pin_event = 1'b0;
         EDGE_FALL: pin_event = pin_filt_d && !pin_filt;
         EDGE_RISE: pin_event = !pin_filt_d && pin_filt;
         EDGE_BOTH: pin_event = pin_filt_d != pin_filt;
      endcase
   end
   assign vbus_event = vbus_s && !vbus_d;

   // Sticky status, write-one clear, enable; a new event wins over a clear
   logic [1:0] irq_status_reg, irq_enable_reg, irq_set;
   assign irq_set = {vbus_event, pin_event};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_reg <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~(wr_clr ? w_data_reg[1:0] : 2'b00))
                           | irq_set;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg <= '0;
      end else if (wr_en && w_strb_reg[0]) begin
         irq_enable_reg <= w_data_reg[1:0];
      end
   end
   assign irq = |(irq_status_reg & irq_enable_reg);

   // Read side
   logic [23:0] pin_view, rd_word;
   logic rd_hit;
   assign pin_view = (pin_reg & `PIN_MASK & ~24'h000002) | {22'h000000, pin_filt, 1'b0};
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr[7:2])
         `IDX_SWITCHER_MODE_UPPER: rd_word = sw_mode_reg;
         `IDX_LINEAR_VOLTAGE: rd_word = volt_reg & `LIN_VOLT_MASK;
         `IDX_BOOST_CONTROL: rd_word = boost_reg & `BOOST_MASK;
         `IDX_LINEAR_ENABLE_MODE: rd_word = lin_reg & `LIN_EN_MASK;
         `IDX_PIN0_CONTROL: rd_word = pin_view;
         `IDX_IRQ_STATUS: rd_word = {22'h000000, irq_status_reg};
         `IDX_IRQ_CLEAR: rd_word = '0;
         `IDX_IRQ_ENABLE: rd_word = {22'h000000, irq_enable_reg};
         default: begin
            rd_word = '0;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {8'h00, rd_word};
         s_axi_rresp <= rd_hit ? 2'b00 : 2'b11;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign switcher_mode_word = sw_mode_reg;
   assign linear_voltage_word = volt_reg;
   assign boost_control_word = boost_reg;
   assign usb_regulator_on = lin_reg[`LIN_USB_ON_BIT];

   sequence seq_load_s;
      seq_reg == SEQ_LOAD && main_s && off_s && !wr_sw;
   endsequence
   sequence rise_seen_s;
      edge_sel == EDGE_RISE && !pin_filt_d && pin_filt;
   endsequence

   AST_SEQ_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_load_s |=> sw_mode_reg[3:0] == ($past(sw_en_s[0]) ? `SW_MODE_APS : `SW_MODE_OFF))
      else $error("sequencer did not load switcher mode");
   AST_SEQ_APS: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_load_s ##0 sw_en_s[3] |=> sw_mode_reg[21:18] == `SW_MODE_APS)
      else $error("enabled switcher not in pulse-skip mode");
   AST_OFF_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
      !off_s |=> (sw_mode_reg & `SW_OFF_RESET_MASK) == 24'h000000)
      else $error("off reset left hold bits set");
   AST_USB_FORCE: assert property (@(posedge mclk) disable iff (!rst_n)
      vbus_s |=> usb_regulator_on)
      else $error("usb regulator not forced on");
   AST_PASS_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
      seq_load_s |=> lin_reg[`LIN_GEN2_PASS_BIT] == $past(strap_s[`STRAP_PASS_BIT])
                  && lin_reg[`LIN_USB2_PASS_BIT] == $past(strap_s[`STRAP_PASS_BIT]))
      else $error("pass select does not follow strap");
   AST_STANDBY: assert property (@(posedge mclk) disable iff (!rst_n)
      (stby_s && lin_stby[0]) |=> !linear_reg_on[0])
      else $error("standby did not switch regulator off");
   AST_INPUT_HIZ: assert property (@(posedge mclk) disable iff (!rst_n)
      !pin_reg[`PIN_DIR_BIT] |=> low_voltage_pin0_oe_n)
      else $error("input pin is driven");
   AST_PUSH_PULL: assert property (@(posedge mclk) disable iff (!rst_n)
      (pin_reg[`PIN_DIR_BIT] && !pin_reg[`PIN_OD_BIT]) |=>
         !low_voltage_pin0_oe_n && low_voltage_pin0_out == $past(pin_reg[`PIN_DOUT_BIT]))
      else $error("push-pull output wrong");
   AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!rst_n)
      (pin_reg[`PIN_OD_BIT] && pin_reg[`PIN_DOUT_BIT]) |=> low_voltage_pin0_oe_n)
      else $error("open-drain output drove high");
   AST_DIN_VIEW: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `IDX_PIN0_CONTROL) |=>
         s_axi_rdata[`PIN_DIN_BIT] == $past(pin_filt))
      else $error("input state bit wrong");
   AST_RISE_EVENT: assert property (@(posedge mclk) disable iff (!rst_n)
      rise_seen_s |=> irq_status_reg[`IRQ_PIN_BIT])
      else $error("rising edge not latched");
   AST_READ_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
      s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
      else $error("unused bits read nonzero");
   AST_PIN_UNUSED: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `IDX_PIN0_CONTROL) |=>
         s_axi_rdata[31:16] == 16'h0000)
      else $error("unused pin control bits read nonzero");

endmodule : pmic_regulator_gpio_regs
`default_nettype wire

// ===== tb_pmic_regulator_gpio_regs.sv
// Self-checking bench for the regulator and pin control bank.
// Assumes the bank header, package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pmic_bank_regs.svh"
module tb_pmic_regulator_gpio_regs;
   import pmic_bank_pkg::*;
   typedef struct packed {logic w; logic [5:0] i; logic [31:0] d, e; logic [1:0] r;} row_t;
   logic mclk = '0, rst_n = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
   logic rready = '0, main_n = '1, off_n = '1, vbus = '0, stby = '0, pin = '0;
   logic awready, wready, bvalid, arready, rvalid, pin_out, oe_n, irq;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [4:0] reg_on;
   logic [4:0] strap = 5'h10;
   logic [23:0] sw_word, volt_word, boost_word;
   logic [7:0] pad_cfg;
   logic usb_on;
   int error_cnt = 0, n_compared = 0;
   row_t rows [11] = '{'{1'h0, 6'h1D, 32'h0, 32'h200008, 2'h0}, '{1'h0, 6'h1E, 32'h0, 32'h0, 2'h0},
      '{1'h0, 6'h1F, 32'h0, 32'h48, 2'h0}, '{1'h0, 6'h20, 32'h0, 32'h020808, 2'h0},
      '{1'h0, 6'h21, 32'h0, 32'h3808, 2'h0}, '{1'h1, 6'h1E, '1, 32'h1FF7, 2'h0},
      '{1'h1, 6'h1F, '1, 32'hFF, 2'h0}, '{1'h1, 6'h20, '1, 32'h1FFC7F, 2'h0},
      '{1'h1, 6'h20, 32'h0, 32'h020800, 2'h0}, '{1'h1, 6'h21, '1, 32'hFFFD, 2'h0},
      '{1'h1, 6'h30, '1, 32'h0, 2'h3}};
   logic [11:0] pv [3] = '{12'h005, 12'h205, 12'h201};
   logic [1:0] pe [3] = '{2'h1, 2'h2, 2'h0};

   always #50 mclk = ~mclk;

   pmic_regulator_gpio_regs #(.MS_CYCLES(10)) u_dut (.mclk, .rst_n, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .main_reset_n(main_n), .off_reset_n(off_n), .powerup_strap(strap),
      .switcher_startup_en(4'h9), .vbus_invalid(vbus), .standby(stby),
      .low_voltage_pin0_in(pin), .low_voltage_pin0_out(pin_out), .low_voltage_pin0_oe_n(oe_n),
      .pin0_pad_cfg(pad_cfg), .switcher_mode_word(sw_word), .linear_voltage_word(volt_word),
      .boost_control_word(boost_word), .linear_reg_on(reg_on), .usb_regulator_on(usb_on), .irq);

   task automatic end_of_test;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] %0t got %h exp %h", $time, g, e);
         error_cnt++;
      end
   endtask : chk

   task automatic lim(input int n);
      if (n == 60) begin
         error_cnt++;
         end_of_test;
      end
   endtask : lim

   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      int n;
      @(posedge mclk);
      awaddr <= {i, 2'h0};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 60; n++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      rs = bresp;
      bready <= 1'h0;
      lim(n);
   endtask : wr

   task automatic rdr(input logic [5:0] i);
      int n;
      @(posedge mclk);
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 60; n++) begin
         @(posedge mclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
      lim(n);
   endtask : rdr

   task automatic pulse_main(input logic off);
      @(posedge mclk);
      if (off) off_n <= 1'h0;
      else main_n <= 1'h0;
      repeat (4) @(posedge mclk);
      off_n <= 1'h1;
      main_n <= 1'h1;
      repeat (12) @(posedge mclk);
   endtask : pulse_main

   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (12) @(posedge mclk);
      chk({pad_cfg, usb_on}, 32'h139);
      chk(sw_word, 32'h200008);
      chk({boost_word, volt_word[7:0]}, 32'h4800);
      foreach (rows[k]) begin
         if (rows[k].w) wr(rows[k].i, rows[k].d);
         if (rows[k].w) chk(rs, rows[k].r);
         rdr(rows[k].i);
         chk(rs, rows[k].r);
         if (rows[k].r == 2'h0) chk(rd, rows[k].e);
      end
      wr(6'h1D, '1);
      pulse_main(1'h0);
      rdr(6'h1D);
      chk(rd, 32'hE30C38);
      pulse_main(1'h1);
      rdr(6'h1D);
      chk(rd, 32'h200008);
      wr(6'h20, 32'h0);
      @(posedge mclk);
      vbus <= 1'h1;
      repeat (6) @(posedge mclk);
      rdr(6'h20);
      chk(rd[3], 1'h1);
      @(negedge mclk);
      chk(irq, 1'h0);
      wr(6'h24, 32'h2);
      @(negedge mclk);
      chk(irq, 1'h1);
      wr(6'h23, 32'h2);
      @(negedge mclk);
      chk(irq, 1'h0);
      wr(6'h21, 32'h90);
      wr(6'h24, 32'h1);
      @(posedge mclk);
      pin <= 1'h1;
      repeat (90) @(posedge mclk);
      rdr(6'h21);
      chk(rd[1], 1'h0);
      repeat (100) @(posedge mclk);
      rdr(6'h21);
      chk(rd[1], 1'h1);
      chk(irq, 1'h1);
      wr(6'h23, 32'h1);
      wr(6'h21, 32'hD0);
      @(posedge mclk);
      pin <= 1'h0;
      repeat (150) @(posedge mclk);
      @(negedge mclk);
      chk(irq, 1'h1);
      wr(6'h23, 32'h1);
      wr(6'h21, 32'h50);
      @(posedge mclk);
      pin <= 1'h1;
      repeat (150) @(posedge mclk);
      @(negedge mclk);
      chk(irq, 1'h0);
      for (int k = 0; k < 3; k++) begin
         wr(6'h21, {20'h0, pv[k]});
         repeat (2) @(negedge mclk);
         chk({oe_n, pin_out}, pe[k]);
      end
      wr(6'h20, 32'h3);
      @(negedge mclk);
      chk(reg_on[0], 1'h1);
      @(posedge mclk);
      stby <= 1'h1;
      repeat (6) @(negedge mclk);
      chk(reg_on[0], 1'h0);
      @(posedge mclk);
      rst_n <= 1'h0;
      strap <= 5'h00;
      @(negedge mclk);
      chk({awready, wready, arready, bvalid, rvalid, oe_n, irq, reg_on}, 32'hE40);
      repeat (4) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (12) @(posedge mclk);
      rdr(6'h20);
      chk(rd, 32'h000008);
      rdr(6'h21);
      chk(rd, 32'h380A);
      rdr(6'h22);
      chk(rd, 32'h2);
      end_of_test;
   end
endmodule : tb_pmic_regulator_gpio_regs
`default_nettype wire
